// ==== hw/ilktx_dev.sv ====
// Purpose: Core end of the transmit user port with buffer and burst scheduler.
// Assumes: Burst length settings are static byte counts.
// Notes: The link side pops one buffered cycle per accepted output beat.
`timescale 1ns/10ps
`default_nettype none
`include "ilktx_defines.svh"

// Overview of operation
// - Build-time mode: interleaved or packet only.
// - Packet mode ignores markers, schedules bursts itself.
// - Interleaved: markers make burst words, short length kept.
// - Application keeps interleaved bursts within 1024 bytes; ilktx_app passes longer ones through and only flags them.
// - Non-interleaved traffic accepted; markers still required.
// - Receive logic must accept interleaved bursts.
// - Remote sender honours short length, 64-byte packets.
// - Start flag comes with data and channel.
// - Start cycle sampled as first packet data.
// - Four-bit count gives valid words, eight maximum.
// - End bit marks last cycle, low bits bytes.
// - Nonzero count writes data and controls.
// - Application drives zero count when idle.
// - Ready is inverse of buffer almost full.
// - Writes accepted for four cycles after ready falls.
// - Application stops within six to eight cycles.
// - Interleaved application schedules and marks bursts.
// - Channel meaningful only with packet or burst start.
// - Valid words sit in top positions.
// - Zero count is an idle cycle.
module ilktx_dev #(
  parameter ilktx_pkg::ilktx_mode_t MODE = ilktx_pkg::ILKTX_MODE_INTERLEAVED,
  parameter int DEPTH = `ILKTX_FIFO_DEPTH,
  parameter int HEADROOM = `ILKTX_AF_HEADROOM
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  ilktx_if.dev port,
  input wire logic [`ILKTX_LEN_W-1:0] i_max_burst_length_setting,
  input wire logic [`ILKTX_LEN_W-1:0] i_min_burst_length_setting,
  input wire logic [`ILKTX_LEN_W-1:0] i_short_burst_length_setting,
  input wire logic i_link_ready,
  output logic o_link_valid,
  output var ilktx_pkg::ilktx_beat_t o_link_beat,
  output logic o_link_burst_ctrl,
  output logic o_link_burst_end,
  output logic o_overflow
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic ready;
    logic [`ILKTX_CHAN_W-1:0] last_chan;
    logic link_valid;
    ilktx_pkg::ilktx_beat_t link_beat;
    logic link_ctrl;
    logic link_end;
    logic in_burst;
    logic [`ILKTX_LEN_W:0] burst_bytes;
    logic [`ILKTX_LEN_W-1:0] gap;
    logic overflow;
  } ilktx_dev_state_t;

  ilktx_dev_state_t state_reg;
  ilktx_dev_state_t state_next;
  ilktx_pkg::ilktx_beat_t buf_mem [DEPTH];
  ilktx_pkg::ilktx_beat_t wr_beat;
  ilktx_pkg::ilktx_beat_t rd_beat;
  logic [AW:0] fill;
  logic [AW:0] fill_next;
  logic full;
  logic wr_en;
  logic rd_en;
  logic pkt_mode;
  logic [`ILKTX_LEN_W:0] beat_bytes;
  logic [`ILKTX_LEN_W:0] sum_bytes;
  logic [`ILKTX_LEN_W:0] gap_need;
  logic [`ILKTX_LEN_W:0] gap_bytes;
  logic sob_out;
  logic eob_out;

  ////////////////////////////////////////////////////////////////////////////
  // Write side: every cycle with a nonzero count lands in the buffer unless the buffer is full.
  always_comb begin
    pkt_mode = (MODE == ilktx_pkg::ILKTX_MODE_PACKET);
    fill = state_reg.wr_ptr - state_reg.rd_ptr;
    full = (fill == (AW+1)'(DEPTH));
    // A zero count is idle and writes nothing.
    wr_en = (port.num_valid != 4'h0) && !full;
    wr_beat.data = port.din_words;
    wr_beat.num_valid = port.num_valid;
    wr_beat.eopbits = port.eopbits;
    wr_beat.sop = port.sop;
    // Packet mode has no use for the burst markers.
    wr_beat.sob = pkt_mode ? 1'b0 : port.sob;
    wr_beat.eob = pkt_mode ? 1'b0 : port.eob;
    // The channel is taken only on a start; other cycles reuse it.
    if (port.sop || (!pkt_mode && port.sob)) begin
      wr_beat.chan = port.chan;
    end else begin
      wr_beat.chan = state_reg.last_chan;
    end
  end

  // Buffer storage, kept apart from the state so it needs no reset.
  always_ff @(posedge i_clk) begin
    if (wr_en) begin
      buf_mem[state_reg.wr_ptr[AW-1:0]] <= wr_beat;
    end
  end

  assign rd_beat = buf_mem[state_reg.rd_ptr[AW-1:0]];

  ////////////////////////////////////////////////////////////////////////////
  // Read side scheduler and flow control.
  always_comb begin
    state_next = state_reg;
    beat_bytes = {6'h00, rd_beat.num_valid, 3'h0};
    sum_bytes = state_reg.burst_bytes + beat_bytes;
    sob_out = 1'b0;
    eob_out = 1'b0;
    gap_need = '0;
    gap_bytes = '0;
    rd_en = 1'b0;
    if (wr_en) begin
      state_next.wr_ptr = state_reg.wr_ptr + (AW+1)'(1);
      state_next.last_chan = wr_beat.chan;
    end
    // Writes beyond the buffer are lost and flagged.
    if ((port.num_valid != 4'h0) && full) begin
      state_next.overflow = 1'b1;
    end
    if (state_reg.gap != '0) begin
      state_next.gap = state_reg.gap - `ILKTX_LEN_W'(1);
    end
    if (!state_reg.link_valid || i_link_ready) begin
      state_next.link_valid = 1'b0;
      state_next.link_ctrl = 1'b0;
      state_next.link_end = 1'b0;
      if ((fill != '0) && (state_reg.gap == '0)) begin
        rd_en = 1'b1;
      end
    end
    if (rd_en) begin
      state_next.rd_ptr = state_reg.rd_ptr + (AW+1)'(1);
      if (pkt_mode) begin
        // Own bursts: open on need, close at packet end or max length.
        sob_out = !state_reg.in_burst || rd_beat.sop;
        if (sob_out) begin
          sum_bytes = beat_bytes;
        end
        eob_out = rd_beat.eopbits[`ILKTX_EOP_FLAG_BIT] ||
                  (sum_bytes >= {1'b0, i_max_burst_length_setting});
        // Short trailing bursts are padded up to the larger of the minimum and short lengths.
        gap_need = (i_min_burst_length_setting > i_short_burst_length_setting) ?
                   {1'b0, i_min_burst_length_setting} : {1'b0, i_short_burst_length_setting};
      end else begin
        // Markers from the application frame the bursts.
        sob_out = rd_beat.sob;
        if (sob_out) begin
          sum_bytes = beat_bytes;
        end
        eob_out = rd_beat.eob;
        gap_need = {1'b0, i_short_burst_length_setting};
      end
      state_next.link_valid = 1'b1;
      state_next.link_beat = rd_beat;
      state_next.link_beat.sob = sob_out;
      state_next.link_beat.eob = eob_out;
      state_next.link_ctrl = sob_out;
      state_next.link_end = eob_out;
      state_next.in_burst = !eob_out;
      state_next.burst_bytes = eob_out ? '0 : sum_bytes;
      // Idle beats fill a burst that is shorter than the floor.
      if (eob_out && (sum_bytes < gap_need)) begin
        gap_bytes = gap_need - sum_bytes + {1'b0, `ILKTX_BEAT_BYTES} - 13'h1;
        state_next.gap = `ILKTX_LEN_W'(gap_bytes >> `ILKTX_BEAT_SHIFT);
      end
    end
    fill_next = state_next.wr_ptr - state_next.rd_ptr;
    // Headroom covers the grace cycles and the registered return path.
    state_next.ready = (fill_next < (AW+1)'(DEPTH - HEADROOM));
  end

  // State register; reset empties the buffer and drops ready.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign port.ready = state_reg.ready;
  assign o_link_valid = state_reg.link_valid;
  assign o_link_beat = state_reg.link_beat;
  assign o_link_burst_ctrl = state_reg.link_ctrl;
  assign o_link_burst_end = state_reg.link_end;
  assign o_overflow = state_reg.overflow;

endmodule

`default_nettype wire

// ==== hw/ilktx_defines.svh ====
// Purpose: Shared constants of the transmit user port and its application end.
// Assumes: Byte lengths are counted on a bus of eight 64-bit words.
// Notes: Definitions only.
`ifndef ILKTX_DEFINES_SVH
`define ILKTX_DEFINES_SVH

`define ILKTX_WORD_W 64
`define ILKTX_WORDS 8
`define ILKTX_DATA_W 512
`define ILKTX_NV_W 4
`define ILKTX_NV_FULL 4'h8
`define ILKTX_EOP_W 4
`define ILKTX_EOP_FLAG_BIT 3
`define ILKTX_CHAN_W 8
`define ILKTX_LEN_W 12
`define ILKTX_BYTES_PER_WORD 12'h008
`define ILKTX_BEAT_BYTES 12'h040
`define ILKTX_BEAT_SHIFT 6
`define ILKTX_GRACE_CYCLES 4
`define ILKTX_APP_LATE_MAX 8
`define ILKTX_BURST_LIMIT_BYTES 12'h400
`define ILKTX_MIN_PACKET_BYTES 12'h040
`define ILKTX_FIFO_DEPTH 32
`define ILKTX_AF_HEADROOM 10

`endif

// ==== hw/ilktx_pkg.sv ====
// Purpose: Types shared by the transmit user port ends.
// Assumes: Widths come from the defines header.
// Notes: No state lives here.
`include "ilktx_defines.svh"

package ilktx_pkg;

  // Build-time transfer mode of the port.
  typedef enum {
    ILKTX_MODE_INTERLEAVED,
    ILKTX_MODE_PACKET
  } ilktx_mode_t;

  // One user cycle as written into the transmit buffer.
  typedef struct packed {
    logic [`ILKTX_DATA_W-1:0] data;
    logic [`ILKTX_NV_W-1:0] num_valid;
    logic sop;
    logic sob;
    logic eob;
    logic [`ILKTX_EOP_W-1:0] eopbits;
    logic [`ILKTX_CHAN_W-1:0] chan;
  } ilktx_beat_t;

endpackage

// ==== hw/ilktx_if.sv ====
// Purpose: Transmit user data port between application and core.
// Assumes: One clock shared by both ends.
// Notes: Valid words sit in the most significant word positions.
`timescale 1ns/10ps
`default_nettype none
`include "ilktx_defines.svh"

interface ilktx_if;
  logic [`ILKTX_DATA_W-1:0] din_words;
  logic [`ILKTX_NV_W-1:0] num_valid;
  logic sop;
  logic sob;
  logic eob;
  logic [`ILKTX_EOP_W-1:0] eopbits;
  logic [`ILKTX_CHAN_W-1:0] chan;
  logic ready;

  // Core end.
  modport dev (
    input din_words, num_valid, sop, sob, eob, eopbits, chan,
    output ready
  );

  // Application end.
  modport app (
    output din_words, num_valid, sop, sob, eob, eopbits, chan,
    input ready
  );
endinterface

`default_nettype wire

// ==== hw/ilktx_app.sv ====
// Purpose: Application end that writes user cycles onto the transmit port.
// Assumes: The user side offers one cycle at a time with a stall.
// Notes: Outputs are registered, which the core's grace period absorbs.
`timescale 1ns/10ps
`default_nettype none
`include "ilktx_defines.svh"

module ilktx_app #(
  parameter ilktx_pkg::ilktx_mode_t MODE = ilktx_pkg::ILKTX_MODE_INTERLEAVED,
  parameter int GRACE = `ILKTX_GRACE_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  ilktx_if.app port,
  input wire logic i_req_valid,
  input wire ilktx_pkg::ilktx_beat_t i_req_beat,
  output logic o_req_ready,
  output logic o_burst_too_long
);

  typedef struct packed {
    ilktx_pkg::ilktx_beat_t out;
    logic [3:0] late;
    logic [`ILKTX_LEN_W:0] burst_bytes;
    logic too_long;
  } ilktx_app_state_t;

  ilktx_app_state_t state_reg;
  ilktx_app_state_t state_next;
  logic may_send;
  logic take;
  logic [`ILKTX_LEN_W:0] beat_bytes;

  ////////////////////////////////////////////////////////////////////////////
  // Sending stays allowed while ready is high and for the grace cycles after.
  always_comb begin
    may_send = port.ready || (state_reg.late < 4'(GRACE));
    take = i_req_valid && may_send && (i_req_beat.num_valid != 4'h0);
    beat_bytes = {6'h00, i_req_beat.num_valid, 3'h0};
    state_next = state_reg;
    state_next.late = port.ready ? 4'h0 : ((state_reg.late == 4'hf) ? 4'hf : state_reg.late + 4'h1);
    // Idle cycles carry a zero count and no markers.
    state_next.out = '0;
    if (take) begin
      // Start flag, channel and data travel in one cycle.
      state_next.out = i_req_beat;
      if (MODE == ilktx_pkg::ILKTX_MODE_INTERLEAVED) begin
        // Bursts are marked by the user; the length is watched here.
        if (i_req_beat.sob) begin
          state_next.burst_bytes = beat_bytes;
        end else begin
          state_next.burst_bytes = state_reg.burst_bytes + beat_bytes;
        end
        if (state_next.burst_bytes > {1'b0, `ILKTX_BURST_LIMIT_BYTES}) begin
          state_next.too_long = 1'b1;
        end
      end
    end
  end

  // State register.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign port.din_words = state_reg.out.data;
  assign port.num_valid = state_reg.out.num_valid;
  assign port.sop = state_reg.out.sop;
  assign port.sob = state_reg.out.sob;
  assign port.eob = state_reg.out.eob;
  assign port.eopbits = state_reg.out.eopbits;
  assign port.chan = state_reg.out.chan;
  assign o_req_ready = may_send;
  assign o_burst_too_long = state_reg.too_long;

endmodule

`default_nettype wire

// ==== testbench/ilktx_port_props.sv ====
// Purpose: Concurrent checks on the wires between application and core ends.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Sees the interface signals only.
`timescale 1ns/10ps
`default_nettype none
`include "ilktx_defines.svh"

module ilktx_port_props (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [`ILKTX_NV_W-1:0] num_valid,
  input wire logic sop,
  input wire logic sob,
  input wire logic eob,
  input wire logic [`ILKTX_EOP_W-1:0] eopbits,
  input wire logic ready
);
  logic [3:0] late_reg;
  logic [3:0] late_next;

  ////////////////////////////////////////////////////////////////
  // Counts cycles since ready fell, saturating so it never wraps.
  always_comb begin
    late_next = ready ? 4'h0 : ((late_reg == 4'hf) ? late_reg : late_reg + 4'h1);
  end

  // Registers the count.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      late_reg <= 4'h0;
    end else begin
      late_reg <= late_next;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Checks on the port.
  nv_range_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    num_valid <= `ILKTX_NV_FULL) else $error("Valid word count above eight.");
  sop_data_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    sop |-> num_valid != 4'h0) else $error("Packet start without data.");
  idle_quiet_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    num_valid == 4'h0 |-> !(sop || sob || eob) && eopbits == 4'h0) else $error("Idle cycle carries flags.");
  burst_data_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (sob || eob) |-> num_valid != 4'h0) else $error("Burst mark without data.");
  eop_bytes_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    eopbits[2:0] != 3'h0 |-> eopbits[3]) else $error("Byte count outside an end cycle.");
  reset_ready_a: assert property (@(posedge i_clk)
    !i_arst_n |-> !ready) else $error("Ready high in reset.");
  ready_wake_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    $rose(i_arst_n) |=> ready) else $error("Ready late after reset.");
  late_write_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    num_valid != 4'h0 |-> late_reg < 4'h8) else $error("Write too long after ready fell.");
endmodule

`default_nettype wire

// ==== testbench/tb_top.sv ====
// Purpose: Self-checking bench of both ends of the transmit user port.
// Assumes: Interleaved mode, plus a second pair built for packet mode; the bench drains the link side.
// Notes: Link beats are queued and compared with the cycles sent.
`timescale 1ns/10ps
`default_nettype none
`include "ilktx_defines.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end

module tb_top;
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b1;
  logic link_ready = 1'b1;
  logic req_valid = 1'b0;
  ilktx_pkg::ilktx_beat_t req_beat = '0;
  logic req_ready, too_long, link_valid, overflow, link_ctrl, link_end;
  ilktx_pkg::ilktx_beat_t link_beat;
  ilktx_pkg::ilktx_beat_t sent[$];
  ilktx_pkg::ilktx_beat_t got[$];
  logic [1:0] marks[$];
  logic pkt_valid = 1'b0;
  ilktx_pkg::ilktx_beat_t pkt_beat = '0;
  logic pkt_link_valid;
  ilktx_pkg::ilktx_beat_t pkt_link_beat;
  ilktx_pkg::ilktx_beat_t pgot[$];
  logic [7:0] last_chan = 8'h00;
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;
  int seq = 0;

  ilktx_if port ();
  ilktx_if port_pkt ();
  ilktx_app i_ilktx_app (.i_clk(i_clk), .i_arst_n(i_arst_n), .port(port.app), .i_req_valid(req_valid),
    .i_req_beat(req_beat), .o_req_ready(req_ready), .o_burst_too_long(too_long));
  ilktx_dev i_ilktx_dev (.i_clk(i_clk), .i_arst_n(i_arst_n), .port(port.dev),
    .i_max_burst_length_setting(12'h100), .i_min_burst_length_setting(12'h040),
    .i_short_burst_length_setting(12'h020), .i_link_ready(link_ready), .o_link_valid(link_valid),
    .o_link_beat(link_beat), .o_link_burst_ctrl(link_ctrl), .o_link_burst_end(link_end), .o_overflow(overflow));
  // A second pair in packet mode, sharing the link drain.
  ilktx_app #(.MODE(ilktx_pkg::ILKTX_MODE_PACKET)) i_ilktx_app_pkt (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .port(port_pkt.app), .i_req_valid(pkt_valid), .i_req_beat(pkt_beat), .o_req_ready(), .o_burst_too_long());
  ilktx_dev #(.MODE(ilktx_pkg::ILKTX_MODE_PACKET)) i_ilktx_dev_pkt (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .port(port_pkt.dev), .i_max_burst_length_setting(12'h100), .i_min_burst_length_setting(12'h040),
    .i_short_burst_length_setting(12'h020), .i_link_ready(link_ready), .o_link_valid(pkt_link_valid),
    .o_link_beat(pkt_link_beat), .o_link_burst_ctrl(), .o_link_burst_end(), .o_overflow());
  ilktx_port_props i_props (.i_clk(i_clk), .i_arst_n(i_arst_n), .num_valid(port.num_valid),
    .sop(port.sop), .sob(port.sob), .eob(port.eob), .eopbits(port.eopbits), .ready(port.ready));

  ////////////////////////////////////////////////////////////////
  // Makes the 200 MHz clock.
  initial begin
    forever #2.5 i_clk = ~i_clk;
  end

  // Collects link beats and cuts a hang short.
  always @(posedge i_clk) begin
    if (link_valid === 1'b1 && link_ready) begin
      got.push_back(link_beat);
      marks.push_back({link_ctrl, link_end});
    end
    if (pkt_link_valid === 1'b1 && link_ready) begin
      pgot.push_back(pkt_link_beat);
    end
    cycles++;
    if (cycles == 6000) begin
      num_errors++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////
  // Offers one cycle, waits for it to be taken and records what the link must show.
  task automatic send(input logic [3:0] nv, input logic s, b, e, input logic [3:0] eop, input logic [7:0] ch);
    int n;
    ilktx_pkg::ilktx_beat_t want;
    n = 0;
    seq++;
    req_valid = 1'b1;
    req_beat = '{data: {16{seq}}, num_valid: nv, sop: s, sob: b, eob: e, eopbits: eop, chan: ch};
    while (req_ready !== 1'b1 && n < 100) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    @(posedge i_clk);
    #1;
    if (s || b) begin
      last_chan = ch;
    end
    want = req_beat;
    want.chan = last_chan;
    sent.push_back(want);
  endtask

  // Leaves the port idle for one cycle.
  task automatic idle();
    req_valid = 1'b0;
    @(posedge i_clk);
    #1;
  endtask

  // Waits for the link to deliver and compares every beat.
  task automatic drain(input string name);
    int n;
    n = 0;
    while (got.size() < sent.size() && n < 500) begin
      @(posedge i_clk);
      n++;
    end
    repeat (4) @(posedge i_clk);
    #1;
    `CHK(got.size(), sent.size())
    foreach (sent[k]) begin
      if (k < got.size()) begin
        `CHK(got[k], sent[k])
        `CHK(got[k].sob, sent[k].sob)
        `CHK(marks[k], {sent[k].sob, sent[k].eob})
      end
    end
    got.delete();
    marks.delete();
    sent.delete();
    $display("%s done", name);
  endtask

  ////////////////////////////////////////////////////////////////
  // Data offered during reset is dropped and ready stays low.
  task automatic t_reset();
    #1;
    i_arst_n = 1'b0;
    req_valid = 1'b1;
    req_beat.num_valid = 4'h8;
    repeat (20) @(posedge i_clk);
    #1;
    `CHK(port.ready, 1'b0)
    `CHK(link_valid, 1'b0)
    i_arst_n = 1'b1;
    req_valid = 1'b0;
    repeat (3) @(posedge i_clk);
    #1;
    `CHK(port.ready, 1'b1)
    drain("t_reset");
  endtask

  // A 179-byte packet in three cycles.
  task automatic t_pkt179();
    send(4'h8, 1'b1, 1'b1, 1'b0, 4'h0, 8'h02);
    send(4'h8, 1'b0, 1'b0, 1'b0, 4'h0, 8'h02);
    send(4'h7, 1'b0, 1'b0, 1'b1, 4'hb, 8'h02);
    idle();
    drain("t_pkt179");
  endtask

  // Interleaved bursts of several channels with an idle cycle between.
  task automatic t_inter();
    send(4'h8, 1'b1, 1'b1, 1'b0, 4'h0, 8'h02);
    send(4'h8, 1'b0, 1'b0, 1'b1, 4'h0, 8'h09);
    send(4'h3, 1'b1, 1'b1, 1'b1, 4'hb, 8'h04);
    idle();
    send(4'h8, 1'b0, 1'b1, 1'b1, 4'h0, 8'h02);
    send(4'h8, 1'b1, 1'b1, 1'b1, 4'h0, 8'h03);
    send(4'h8, 1'b1, 1'b1, 1'b0, 4'h0, 8'h06);
    send(4'h2, 1'b0, 1'b0, 1'b1, 4'hb, 8'h0c);
    idle();
    drain("t_inter");
    `CHK(too_long, 1'b0)
  endtask

  // Link stalls until ready falls; grace writes must not overflow.
  task automatic t_press();
    link_ready = 1'b0;
    for (int i = 0; i < 40; i++) begin
      if (req_ready !== 1'b1) begin
        break;
      end
      send(4'h8, i == 0, 1'b1, 1'b1, 4'h0, 8'h01);
    end
    idle();
    repeat (10) @(posedge i_clk);
    #1;
    `CHK(port.ready, 1'b0)
    `CHK(overflow, 1'b0)
    link_ready = 1'b1;
    drain("t_press");
    `CHK(port.ready, 1'b1)
  endtask

  // One burst of 1088 bytes is flagged as too long.
  task automatic t_long();
    for (int i = 0; i < 17; i++) begin
      send(4'h8, i == 0, i == 0, i == 16, (i == 16) ? 4'h8 : 4'h0, 8'h07);
    end
    idle();
    drain("t_long");
    `CHK(too_long, 1'b1)
  endtask

  // Packet mode: markers are ignored and the core cuts bursts at the 256-byte maximum.
  task automatic t_packet();
    for (int i = 0; i < 5; i++) begin
      pkt_valid = 1'b1;
      pkt_beat = '{data: {16{i}}, num_valid: 4'h8, sop: i == 0, sob: 1'b1, eob: 1'b1,
        eopbits: (i == 4) ? 4'h8 : 4'h0, chan: (i == 0) ? 8'h05 : 8'h0f};
      @(posedge i_clk);
      #1;
    end
    pkt_valid = 1'b0;
    repeat (10) @(posedge i_clk);
    #1;
    `CHK(pgot.size(), 5)
    foreach (pgot[k]) begin
      `CHK(pgot[k].data, {16{k}})
      `CHK({pgot[k].sob, pgot[k].eob, pgot[k].chan}, {k == 0 || k == 4, k == 3 || k == 4, 8'h05})
    end
    pgot.delete();
    $display("t_packet done");
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_of_test();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Runs the scenarios in order.
  initial begin
    t_reset();
    t_pkt179();
    t_inter();
    t_press();
    t_long();
    t_packet();
    end_of_test();
  end
endmodule

`default_nettype wire
